// ### logic/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
    // ==========================================
    // Register map (byte addresses)
    // ==========================================
    localparam logic [7:0] main_control_offset  = 8'h00;
    localparam logic [7:0] edge_priority_offset = 8'h04;
    localparam logic [7:0] ext_line_offset      = 8'h08;
    localparam logic [7:0] reset_control_offset = 8'h0C;
    localparam logic [7:0] peripheral_offset    = 8'h10;
    localparam logic [7:0] core_status_offset   = 8'h14;

    // ==========================================
    // Reset values
    // ==========================================
    localparam logic [7:0] main_control_reset  = 8'h00;
    localparam logic [7:0] edge_priority_reset = 8'hF5;
    localparam logic [7:0] ext_line_reset      = 8'hC0;
    localparam logic [7:0] reset_control_reset = 8'h00;
    localparam logic [7:0] peripheral_reset    = 8'h00;

    // ==========================================
    // Field positions
    // ==========================================
    localparam int bit_global_high    = 7;
    localparam int bit_global_low     = 6;
    localparam int bit_tmr_enable     = 5;
    localparam int bit_ext0_enable    = 4;
    localparam int bit_port_enable    = 3;
    localparam int bit_tmr_flag       = 2;
    localparam int bit_ext0_flag      = 1;
    localparam int bit_port_flag      = 0;
    localparam int bit_edge0          = 6;
    localparam int bit_edge1          = 5;
    localparam int bit_edge2          = 4;
    localparam int bit_tmr_priority   = 2;
    localparam int bit_port_priority  = 0;
    localparam int bit_ext2_priority  = 7;
    localparam int bit_ext1_priority  = 6;
    localparam int bit_ext2_enable    = 4;
    localparam int bit_ext1_enable    = 3;
    localparam int bit_ext2_flag      = 1;
    localparam int bit_ext1_flag      = 0;
    localparam int bit_priority_mode  = 7;
    localparam int bit_usb_flag       = 0;
    localparam int bit_usb_enable     = 1;
    localparam int bit_usb_priority   = 2;

    // ==========================================
    // Vectors and timing
    // ==========================================
    localparam logic [20:0] high_vector     = 21'h000008;
    localparam logic [20:0] low_vector      = 21'h000018;
    localparam int          ext_latency_cyc = 3;

    localparam logic [1:0] resp_okay   = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    // Vectored request to the core
    typedef struct packed {
        logic        valid;
        logic        high;
        logic [20:0] vector;
    } core_req_s;

    typedef enum logic [2:0] {
        st_idle     = 3'b001,
        st_low_run  = 3'b010,
        st_high_run = 3'b100
    } service_e;
endpackage

// ### logic/irq_ctrl.sv
// Functional notes
// RULE1: priority mode vectors high 000008h, low 000018h
// RULE2: high preempts low; low waits during high
// RULE3: every source has flag, enable, priority; line0 has no priority bit here and is always high
// RULE4: priority mode only while reset control bit7
// RULE5: bit7 gates high sources, bit6 low ones
// RULE6: flag, enable, global set means vector now
// RULE7: compatibility mode sends all to 000008h
// RULE8: compatibility: bit6 peripherals, bit7 everything
// RULE9: taking interrupt clears the enabling global bit
// RULE10: core pushes return address, loads vector
// RULE11: return instruction sets matching global enable
// RULE12: pin events reach core in fixed latency
// RULE13: flags set regardless of any enable
// RULE14: software clears flags; hardware never does
// RULE15: software avoids memory moves on enabled controls
// RULE16: usb events merge into one flag, priority
// RULE17: timer flag bit2, line0 bit1; enables 5,4
// RULE18: upper port change sets bit0; enable bit3
// RULE19: mismatch keeps port flag set until read
// RULE20: edge select per line, reset rising
// RULE21: third register holds line1/2 priority, enable, flag
// RULE22: same-level requests raise one core request
`timescale 1ns/10ps
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic                   aclk,           // Core clock
    input  wire logic                   aresetn,        // Sync reset, active low
    input  wire logic [7:0]             s_axi_awaddr,   // Write address
    input  wire logic                   s_axi_awvalid,  // Write address valid
    output logic                        s_axi_awready,  // Write address ready
    input  wire logic [31:0]            s_axi_wdata,    // Write data
    input  wire logic [3:0]             s_axi_wstrb,    // Write strobes
    input  wire logic                   s_axi_wvalid,   // Write data valid
    output logic                        s_axi_wready,   // Write data ready
    output logic [1:0]                  s_axi_bresp,    // Write response
    output logic                        s_axi_bvalid,   // Write response valid
    input  wire logic                   s_axi_bready,   // Write response ready
    input  wire logic [7:0]             s_axi_araddr,   // Read address
    input  wire logic                   s_axi_arvalid,  // Read address valid
    output logic                        s_axi_arready,  // Read address ready
    output logic [31:0]                 s_axi_rdata,    // Read data
    output logic [1:0]                  s_axi_rresp,    // Read response
    output logic                        s_axi_rvalid,   // Read data valid
    input  wire logic                   s_axi_rready,   // Read data ready
    input  wire logic [2:0]             ext_pins,       // External interrupt pins
    input  wire logic [3:0]             port_b_upper,   // Upper port B pins
    input  wire logic                   port_read,      // Core read of port B, pulse
    input  wire logic                   timer_overflow, // Timer 0 overflow, pulse
    input  wire logic                   usb_event,      // Any USB event, pulse
    input  wire logic                   periph_request, // Other peripherals, level
    input  wire logic                   irq_ack,        // Core took request, pulse
    input  wire logic                   return_from_interrupt_instruction,         // Return instruction, pulse
    output irq_ctrl_pkg::core_req_s     core_req        // Vectored request to core
);
    import irq_ctrl_pkg::*;

    // ==========================================
    // Registers
    // ==========================================
    logic [7:0] main_ctl;
    logic [7:0] edge_ctl;
    logic [7:0] ext_ctl;
    logic [7:0] rst_ctl;
    logic [7:0] periph_ctl;
    service_e   svc;
    logic       low_preempted;

    // Pin synchronisers
    logic [2:0] ext_s1, ext_s2, ext_d;
    logic [3:0] port_s1, port_s2, port_latch;
    logic [1:0] read_delay;

    // Line flops not reset: they follow the pins during reset, so no false edge after it
    always_ff @(posedge aclk) begin
        ext_s1 <= ext_pins;
        ext_s2 <= ext_s1; // RULE12
        ext_d  <= ext_s2;
    end

    // Two flops before any logic looks at pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_s1 <= 4'h0;
            port_s2 <= 4'h0;
        end else begin
            port_s1 <= port_b_upper;
            port_s2 <= port_s1;
        end
    end

    // ==========================================
    // Event detection
    // ==========================================
    logic [2:0] edge_sel;
    logic [2:0] ext_hit;
    logic       port_mismatch;
    assign edge_sel = {edge_ctl[bit_edge2], edge_ctl[bit_edge1], edge_ctl[bit_edge0]};
    // 1 rising, 0 falling per line
    assign ext_hit  = (edge_sel & ext_s2 & ~ext_d) | (~edge_sel & ~ext_s2 & ext_d); // RULE20
    assign port_mismatch = (port_s2 != port_latch); // RULE18

    // Port snapshot taken in the same cycle as a core read ends mismatch
    // Two cycles of hold-off after a read stand in for one instruction cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_latch <= 4'h0;
            read_delay <= 2'b00;
        end else begin
            read_delay <= {read_delay[0], port_read};
            if (port_read) begin
                port_latch <= port_s2; // RULE19
            end
        end
    end
    // ==========================================
    // AXI4-Lite write
    // ==========================================
    logic       aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= resp_okay;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr <= peripheral_offset && aw_addr[1:0] == 2'b00)
                                ? resp_okay : resp_slverr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_en_main, wr_en_edge, wr_en_ext, wr_en_rst, wr_en_per;
    assign wr_en_main = do_write && w_strb[0] && aw_addr == main_control_offset;
    assign wr_en_edge = do_write && w_strb[0] && aw_addr == edge_priority_offset;
    assign wr_en_ext  = do_write && w_strb[0] && aw_addr == ext_line_offset;
    assign wr_en_rst  = do_write && w_strb[0] && aw_addr == reset_control_offset;
    assign wr_en_per  = do_write && w_strb[0] && aw_addr == peripheral_offset;

    // ==========================================
    // Request arbitration
    // ==========================================
    logic prio_mode;
    logic [4:0] src_flag, src_en, src_prio;
    logic per_flag, per_en, per_prio;
    logic high_pend, low_pend, take_high, take_low;
    assign prio_mode = rst_ctl[bit_priority_mode]; // RULE4
    // Timer, line0, line1, line2, port change
    assign src_flag = {main_ctl[bit_port_flag], ext_ctl[bit_ext2_flag], ext_ctl[bit_ext1_flag],
                       main_ctl[bit_ext0_flag], main_ctl[bit_tmr_flag]}; // RULE3
    assign src_en   = {main_ctl[bit_port_enable], ext_ctl[bit_ext2_enable], ext_ctl[bit_ext1_enable],
                       main_ctl[bit_ext0_enable], main_ctl[bit_tmr_enable]};
    // Line 0 has no priority bit, always high
    assign src_prio = {edge_ctl[bit_port_priority], ext_ctl[bit_ext2_priority],
                       ext_ctl[bit_ext1_priority], 1'b1, edge_ctl[bit_tmr_priority]};
    // USB merged source plus other peripherals as one group
    assign per_flag = periph_ctl[bit_usb_flag] | periph_request; // RULE16
    assign per_en   = periph_ctl[bit_usb_enable];
    assign per_prio = periph_ctl[bit_usb_priority]; // RULE16

    always_comb begin
        if (prio_mode) begin
            // Level set by each source's priority bit, line 0 fixed high
            high_pend = main_ctl[bit_global_high] &&
                        ((|(src_flag & src_en & src_prio)) || (per_flag && per_en && per_prio)); // RULE5 RULE6
            low_pend  = main_ctl[bit_global_low] &&
                        ((|(src_flag & src_en & ~src_prio)) || (per_flag && per_en && !per_prio)); // RULE5
        end else begin
            // Priority bits ignored, single level
            high_pend = main_ctl[bit_global_high] && ((|(src_flag & src_en)) ||
                        (main_ctl[bit_global_low] && per_flag && per_en)); // RULE7 RULE8
            low_pend  = 1'b0;
        end
    end
    // High always wins, low never during high service
    assign take_high = high_pend && svc != st_high_run; // RULE2 RULE22
    assign take_low  = low_pend && !take_high && svc == st_idle; // RULE2

    // Service-level tracker
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            svc           <= st_idle;
            low_preempted <= 1'b0;
        end else if (irq_ack && core_req.valid) begin
            low_preempted <= core_req.high && svc == st_low_run;
            svc           <= core_req.high ? st_high_run : st_low_run;
        end else if (return_from_interrupt_instruction) begin
            case (svc)
                st_high_run: svc <= low_preempted ? st_low_run : st_idle;
                st_low_run:  svc <= st_idle;
                default:     svc <= st_idle;
            endcase
            if (svc == st_high_run) begin
                low_preempted <= 1'b0;
            end
        end
    end

    // Request to core; core pushes return address and jumps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_req <= '0;
        end else begin
            core_req.valid  <= (take_high || take_low) && !(irq_ack && core_req.valid); // RULE10
            core_req.high   <= take_high || !prio_mode;
            core_req.vector <= (take_high || !prio_mode) ? high_vector : low_vector; // RULE1 RULE7
        end
    end

    // ==========================================
    // Main control: flags set beat clears
    // ==========================================
    logic taken;
    assign taken = irq_ack && core_req.valid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_ctl <= main_control_reset;
        end else begin
            if (wr_en_main) begin
                main_ctl <= w_data[7:0];
            end
            // Clear the global bit that allowed entry
            if (taken) begin
                if (core_req.high) main_ctl[bit_global_high] <= 1'b0; // RULE9
                else               main_ctl[bit_global_low]  <= 1'b0; // RULE9
            end else if (return_from_interrupt_instruction) begin
                if (!prio_mode || svc == st_high_run) main_ctl[bit_global_high] <= 1'b1; // RULE11
                else                                  main_ctl[bit_global_low]  <= 1'b1; // RULE11
            end
            // Events override any same-cycle clear, no enable needed
            if (timer_overflow) main_ctl[bit_tmr_flag]  <= 1'b1; // RULE13 RULE17
            if (ext_hit[0])     main_ctl[bit_ext0_flag] <= 1'b1; // RULE17
            if (port_mismatch && read_delay == 2'b00 && !port_read)
                main_ctl[bit_port_flag] <= 1'b1; // RULE18 RULE19
        end
    end

    // Edge select and priorities
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_ctl <= edge_priority_reset; // RULE20
        end else if (wr_en_edge) begin
            // Bits 3 and 1 do not exist and read as zero
            edge_ctl <= w_data[7:0] & 8'hF5;
        end
    end

    // Third register, lines 1 and 2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_ctl <= ext_line_reset;
        end else begin
            if (wr_en_ext) begin
                ext_ctl <= w_data[7:0] & 8'hDB; // RULE21
            end
            if (ext_hit[1]) ext_ctl[bit_ext1_flag] <= 1'b1; // RULE13
            if (ext_hit[2]) ext_ctl[bit_ext2_flag] <= 1'b1; // RULE13
        end
    end

    // Priority mode and USB group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_ctl    <= reset_control_reset;
            periph_ctl <= peripheral_reset;
        end else begin
            if (wr_en_rst) rst_ctl <= w_data[7:0] & 8'h80;
            if (wr_en_per) periph_ctl <= w_data[7:0] & 8'h07;
            if (usb_event) periph_ctl[bit_usb_flag] <= 1'b1; // RULE16 RULE13
        end
    end

    // ==========================================
    // AXI4-Lite read
    // ==========================================
    logic [7:0] rd_val;
    always_comb begin
        case (s_axi_araddr)
            main_control_offset:  rd_val = main_ctl;
            edge_priority_offset: rd_val = edge_ctl;
            ext_line_offset:      rd_val = ext_ctl;
            reset_control_offset: rd_val = rst_ctl;
            peripheral_offset:    rd_val = periph_ctl;
            core_status_offset:   rd_val = {5'h00, svc};
            default:              rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= resp_okay;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h0, rd_val};
                s_axi_rresp  <= (s_axi_araddr <= core_status_offset && s_axi_araddr[1:0] == 2'b00)
                                ? resp_okay : resp_slverr;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    a_high_vector: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        core_req.valid && core_req.high |-> core_req.vector == 21'h000008)
        else $error("high request not at 000008h");
    a_low_vector: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        core_req.valid && !core_req.high |-> core_req.vector == 21'h000018 && prio_mode)
        else $error("low request wrong vector or mode");
    a_no_low_in_high: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        svc == st_high_run |=> !(core_req.valid && !core_req.high))
        else $error("low request during high service");
    a_compat_single: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        $past(!prio_mode) && core_req.valid |-> core_req.high)
        else $error("compat request not single vector");
    a_entry_clears: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        irq_ack && core_req.valid && core_req.high && !wr_en_main |=> !main_ctl[bit_global_high])
        else $error("global enable not cleared on entry");
    a_return_sets: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        return_from_interrupt_instruction && !irq_ack && !prio_mode && !wr_en_main |=> main_ctl[bit_global_high])
        else $error("return did not restore global enable");
    a_timer_flag: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        timer_overflow |=> main_ctl[bit_tmr_flag])
        else $error("timer flag not set");
    a_ext_latency: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
        ext_hit[1] |=> ext_ctl[bit_ext1_flag] ##0 1'b1 [*2])
        else $error("line one flag lost");
    a_ext_request: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
        ext_hit[0] && main_ctl[bit_ext0_enable] && main_ctl[bit_global_high] && !core_req.valid && !wr_en_main
        && svc != st_high_run |=> ##[1:2] ((core_req.valid && core_req.high) || svc == st_high_run))
        else $error("line zero request late");
    a_flag_kept: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
        main_ctl[bit_tmr_flag] && !wr_en_main |=> main_ctl[bit_tmr_flag])
        else $error("flag cleared by hardware");
endmodule

// ### tb/core_model.sv
`timescale 1ns/10ps
module core_model
    import irq_ctrl_pkg::*;
(
    input  wire logic               aclk,    // Core clock
    input  wire logic               aresetn, // Sync reset, active low
    input  irq_ctrl_pkg::core_req_s req,     // Vectored request
    input  wire logic               slow,    // Long gap between entries
    input  wire logic               ret_cmd, // Run return instruction
    output logic                    irq_ack, // Entry taken, pulse
    output logic                    return_from_interrupt_instruction,  // Return instruction, pulse
    output logic [20:0]             pc,      // Vector loaded on entry
    output int                      depth    // Return addresses stacked
);
    logic [2:0] hold;
    // ==========================================
    // Program sequencer
    // ==========================================
    // Gap after an entry, so a request that has not dropped yet is not taken twice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {irq_ack, return_from_interrupt_instruction, hold, pc, depth} <= '0;
        end else begin
            irq_ack <= (hold == 3'h0) && req.valid;
            return_from_interrupt_instruction <= ret_cmd;
            hold <= (hold != 3'h0) ? hold - 3'h1 : (req.valid ? (slow ? 3'h7 : 3'h2) : 3'h0);
            if (hold == 3'h0 && req.valid) begin
                pc <= req.vector;
            end
            depth <= depth + int'(hold == 3'h0 && req.valid) - int'(ret_cmd);
        end
    end
endmodule

// ### tb/two_level_interrupt_controller_test.sv
`timescale 1ns/10ps
module two_level_interrupt_controller_test;
    import irq_ctrl_pkg::*;
    logic        aclk = 0, aresetn = 0, slow = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd_v;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq_ack, return_from_interrupt_instruction;
    logic [1:0]  bresp, rresp, rd_r;
    logic [2:0]  ext_pins = 0, e;
    logic [3:0]  port_b = 0, ev = 0;
    logic [20:0] pc;
    core_req_s   core_req;
    int          depth, d0, fail_count = 0, n_checks = 0;

    // Core clock, 4 ns
    always #2 aclk = ~aclk;

    irq_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_pins(ext_pins),
        .port_b_upper(port_b), .port_read(ev[2]), .timer_overflow(ev[0]), .usb_event(ev[1]),
        .periph_request(1'h0), .irq_ack(irq_ack), .return_from_interrupt_instruction(return_from_interrupt_instruction), .core_req(core_req));
    core_model cm_u (.aclk(aclk), .aresetn(aresetn), .req(core_req), .slow(slow), .ret_cmd(ev[3]),
        .irq_ack(irq_ack), .return_from_interrupt_instruction(return_from_interrupt_instruction), .pc(pc), .depth(depth));

    // ==========================================
    // Bus and check tasks
    // ==========================================
    // One access; each channel is released at the edge that takes it
    task automatic axi(input bit w, input logic [7:0] a, input logic [7:0] d);
        bit ta, tw, tr;
        {ta, tw, tr} = {1'b0, !w, 1'b0};
        if (w) {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'h7};
        else {araddr, arvalid, rready} <= {a, 2'h3};
        while (!tr) begin
            @(posedge aclk);
            if (!ta && (w ? awready : arready)) begin
                ta = 1'b1;
                {awvalid, arvalid} <= 2'h0;
            end
            if (!tw && wready) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
            if (w ? bvalid : rvalid) begin
                {tr, rd_v, rd_r} = {1'b1, rdata, w ? bresp : rresp};
                {bready, rready} <= 2'h0;
            end
        end
        @(posedge aclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            $display("unexpected %s: expected %h seen %h", nm, x, g);
            fail_count++;
        end
    endtask
    // Single register writes only; no block moves while enabled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        axi(1, a, d);
        chk("bresp", resp_okay, rd_r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] x);
        axi(0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, x}, rd_v);
    endtask
    // Event pulse: 0 timer, 1 usb, 2 port read, 3 return
    task automatic pulse(input int k);
        d0 = depth;
        ev[k] <= 1'h1;
        @(posedge aclk);
        ev[k] <= 1'h0;
        repeat (4) @(posedge aclk);
    endtask
    task automatic take(input logic [20:0] v);
        for (int i = 0; i < 40 && depth == d0; i++) @(posedge aclk);
        chk("entries", d0 + 1, depth);
        chk("vector", {11'h0, v}, {11'h0, pc});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        final_report;
    end

    // ==========================================
    // Tests
    // ==========================================
    initial begin
        void'($urandom(64971));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rchk(main_control_offset, main_control_reset);
        rchk(edge_priority_offset, edge_priority_reset);
        rchk(ext_line_offset, ext_line_reset);
        rchk(reset_control_offset, reset_control_reset);
        rchk(peripheral_offset, peripheral_reset);
        rchk(core_status_offset, 8'h01);
        axi(0, 8'h20, 8'h00);
        chk("resp", resp_slverr, rd_r);
        $display("test reset done");
        wr(main_control_offset, 8'hA0);
        pulse(0);
        take(high_vector);
        rchk(main_control_offset, 8'h24);
        wr(main_control_offset, 8'h20);
        pulse(3);
        rchk(main_control_offset, 8'hA0);
        wr(main_control_offset, 8'h80);
        wr(peripheral_offset, 8'h02);
        pulse(1);
        repeat (20) @(posedge aclk);
        chk("entries", d0, depth);
        rchk(peripheral_offset, 8'h03);
        wr(main_control_offset, 8'hC0);
        take(high_vector);
        rchk(main_control_offset, 8'h40);
        wr(peripheral_offset, 8'h00);
        pulse(3);
        rchk(main_control_offset, 8'hC0);
        $display("test compat done");
        wr(reset_control_offset, 8'h80);
        wr(edge_priority_offset, 8'h70);
        wr(main_control_offset, 8'hF0);
        slow <= 1'h1;
        pulse(0);
        take(low_vector);
        rchk(core_status_offset, 8'h02);
        rchk(main_control_offset, 8'hB4);
        d0 = depth;
        ext_pins[0] <= 1'h1;
        take(high_vector);
        rchk(core_status_offset, 8'h04);
        rchk(main_control_offset, 8'h36);
        wr(main_control_offset, 8'h30);
        pulse(3);
        rchk(main_control_offset, 8'hB0);
        rchk(core_status_offset, 8'h02);
        pulse(3);
        rchk(main_control_offset, 8'hF0);
        {slow, ext_pins[0]} <= 2'h0;
        $display("test priority done");
        wr(main_control_offset, 8'h00);
        // Corners first, then random edge selects
        for (int i = 0; i < 6; i++) begin
            e = (i < 2) ? {3{i[0]}} : 3'($urandom);
            wr(edge_priority_offset, {1'b0, e[0], e[1], e[2], 4'h0});
            ext_pins <= ~e;
            repeat (8) @(posedge aclk);
            wr(main_control_offset, 8'h00);
            wr(ext_line_offset, 8'hC0);
            ext_pins <= e;
            repeat (8) @(posedge aclk);
            rchk(ext_line_offset, 8'hC3);
            rchk(main_control_offset, 8'h02);
            wr(ext_line_offset, 8'hC0);
            wr(main_control_offset, 8'h00);
            ext_pins <= ~e;
            repeat (8) @(posedge aclk);
            rchk(ext_line_offset, 8'hC0);
        end
        $display("test edges done");
        pulse(2);
        port_b <= 4'($urandom) | 4'h1;
        repeat (8) @(posedge aclk);
        rchk(main_control_offset, 8'h01);
        wr(main_control_offset, 8'h00);
        rchk(main_control_offset, 8'h01);
        pulse(2);
        wr(main_control_offset, 8'h00);
        rchk(main_control_offset, 8'h00);
        $display("test port done");
        final_report;
    end
endmodule
